//--- src/uart_consts.svh
// register map, field positions, reset values and divisors of the port
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define OFF_SC      8'h98
`define OFF_CFG     8'h9C
`define OFF_ADDR    8'hA0
`define OFF_IST     8'hA4
`define OFF_IMASK   8'hA8
`define OFF_BITWR   8'hAC
`define OFF_DATA    8'hB0
`define SC_RESET    8'h00
`define CFG_RESET   32'h0000_1000
`define ADDR_RESET  16'h0000
`define IRQ_RESET   3'h0
`define SC_MODE0    7
`define SC_MODE1    6
`define SC_MPE      5
`define SC_REN      4
`define SC_TB8      3
`define SC_RB8      2
`define SC_TI       1
`define SC_RI       0
`define CFG_FE_SEL  0
`define CFG_DOUBLER 1
`define CFG_X2      2
`define CFG_DIV_LO  8
`define CFG_DIV_HI  19
`define BW_VAL      3
`define IRQ_TX      0
`define IRQ_RX      1
`define IRQ_FE      2
`define DIV_MODE0   12'h00C
`define DIV_MODE2   12'h040
`define LAST8       4'h7
`define LAST9       4'h8
`endif

//--- src/uart_pkg.sv
// types shared by the serial port modules
package uart_pkg;
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_UART8 = 2'h1,
        MODE_FIX9  = 2'h2,
        MODE_VAR9  = 2'h3
    } mode_t;
    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_BITS  = 4'h4,
        TX_STOP  = 4'h8
    } tx_state_t;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_BITS  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_t;
    typedef logic [11:0] period_t;
    typedef logic [7:0]  apb_addr_t;
    typedef logic [31:0] apb_data_t;
endpackage

//--- src/baud_if.sv
// bit timer control: period and restart in, mid and end pulses out
`timescale 1ns/10ps
interface baud_if;
    uart_pkg::period_t period;
    logic              restart;
    logic              mid;
    logic              tick;
    modport ctl (output period, output restart, input mid, input tick);
    modport gen (input period, input restart, output mid, output tick);
endinterface

//--- src/baud_tick.sv
// bit timer: pulses at mid bit and at the end of every bit period
`timescale 1ns/10ps
module baud_tick (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    baud_if.gen       bi        // period in, pulses out
);
    import uart_pkg::*;
    period_t cnt_reg;
    period_t cnt_next;
    // >= keeps the count bounded when the period shrinks mid bit
    always_comb
    begin
        cnt_next = cnt_reg + 12'h001;
        if (bi.restart || cnt_reg >= bi.period - 12'h001)
            cnt_next = 12'h000;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 12'h000;
        else
            cnt_reg <= cnt_next;
    end
    assign bi.tick = !bi.restart && (cnt_reg == bi.period - 12'h001);
    assign bi.mid  = !bi.restart && (cnt_reg == (bi.period >> 1));
endmodule // baud_tick

//--- src/uart_serial_control.sv
// serial port control register, shift engines and apb slave
`timescale 1ns/10ps
`include "uart_consts.svh"
module uart_serial_control (
    input  wire logic                pclk,     // 20 MHz clock
    input  wire logic                presetn,  // async reset, low
    input  wire logic                psel,     // apb select
    input  wire logic                penable,  // apb access phase
    input  wire logic                pwrite,   // apb write
    input  wire uart_pkg::apb_addr_t paddr,    // apb byte address
    input  wire uart_pkg::apb_data_t pwdata,   // apb write data
    output uart_pkg::apb_data_t      prdata,   // apb read data
    output logic                     pready,   // apb ready
    output logic                     pslverr,  // unmapped address
    input  wire logic                rxd_in,   // data pin level
    output logic                     rxd_out,  // data pin, mode 0 tx
    output logic                     rxd_oe_n, // low while driving
    output logic                     txd_out,  // tx line / shift clk
    output logic                     irq       // level interrupt
);
    import uart_pkg::*;

    logic       rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
    logic [7:0] serial_control_reg, serial_control_next, wmask, wval;
    logic       fe_reg, fe_next;
    apb_data_t  cfg_reg, cfg_next, prdata_reg, prdata_next;
    logic [15:0] addr_reg, addr_next;
    logic [2:0] ist_reg, ist_next, imask_reg, imask_next;
    logic       irq_reg, irq_next;
    logic [7:0] rx_buf_reg, rx_buf_next;
    logic       pready_reg, pready_next, pslverr_reg, pslverr_next;
    tx_state_t  tx_state_reg, tx_state_next;
    logic [8:0] tx_shift_reg, tx_shift_next;
    logic [3:0] tx_cnt_reg, tx_cnt_next;
    logic       tx_m0_reg, tx_m0_next;
    logic       txd_reg, txd_next, rxd_out_reg, rxd_out_next;
    logic       oe_n_reg, oe_n_next;
    rx_state_t  rx_state_reg, rx_state_next;
    logic [8:0] rx_shift_reg, rx_shift_next, shifted;
    logic [3:0] rx_cnt_reg, rx_cnt_next, rx_last;
    logic       rx_m0_reg, rx_m0_next;
    logic       ti_set, ri_set, fe_set, rb8_load, rb8_val, rx_load;
    logic [7:0] rx_data, ev_data, bc_mask;
    logic       ev_go, ev_ninth, rx_start, tx_go, rx0_go;
    period_t    period;
    mode_t      mode;
    logic       fe_sel, mp, nine, ren, wr, rx_m0_busy;

    baud_if tx_bi ();
    baud_if rx_bi ();
    baud_tick u_tx_baud (.pclk(pclk), .presetn(presetn), .bi(tx_bi));
    baud_tick u_rx_baud (.pclk(pclk), .presetn(presetn), .bi(rx_bi));

    assign mode   = mode_t'({serial_control_reg[`SC_MODE0], serial_control_reg[`SC_MODE1]});
    assign fe_sel = cfg_reg[`CFG_FE_SEL];
    // mode 0 ignores the enable even if software leaves it set
    assign mp     = serial_control_reg[`SC_MPE] && mode != MODE_SHIFT;
    assign nine   = mode[1];
    assign ren    = serial_control_reg[`SC_REN];
    assign wr     = psel && penable && pready_reg && pwrite;
    assign rx_m0_busy = rx_state_reg != RX_IDLE && rx_m0_reg;
    assign rx0_go = mode == MODE_SHIFT && ren && !serial_control_reg[`SC_RI]
                    && rx_state_reg == RX_IDLE
                    && tx_state_reg == TX_IDLE;
    assign tx_go  = wr && paddr == `OFF_DATA && tx_state_reg == TX_IDLE
                    && !rx_m0_busy && !rx0_go;
    assign tx_bi.period  = period;
    assign rx_bi.period  = period;
    assign tx_bi.restart = tx_go;
    assign rx_bi.restart = rx_start;

    always_comb
    begin
        case (mode)
            MODE_SHIFT: period = cfg_reg[`CFG_X2] ? (`DIV_MODE0 >> 1)
                                                  : `DIV_MODE0;
            MODE_FIX9:  period = `DIV_MODE2 >> cfg_reg[`CFG_DOUBLER]
                                 >> cfg_reg[`CFG_X2];
            default:    period = cfg_reg[`CFG_DIV_HI:`CFG_DIV_LO]
                                 >> cfg_reg[`CFG_DOUBLER]
                                 >> cfg_reg[`CFG_X2];
        endcase
        if (period == 12'h000)
            period = 12'h001;
    end

    // apb answers after one wait state so read data comes from a flop
    always_comb
    begin
        pready_next  = psel && penable && !pready_reg;
        pslverr_next = 1'b0;
        prdata_next  = prdata_reg;
        if (pready_next)
        begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                `OFF_SC:    prdata_next = {24'h00_0000,
                                fe_sel ? fe_reg : serial_control_reg[`SC_MODE0],
                                serial_control_reg[6:0]};
                `OFF_CFG:   prdata_next = cfg_reg;
                `OFF_ADDR:  prdata_next = {16'h0000, addr_reg};
                `OFF_IST:   prdata_next = {29'h0000_0000, ist_reg};
                `OFF_IMASK: prdata_next = {29'h0000_0000, imask_reg};
                `OFF_BITWR: prdata_next = 32'h0000_0000;
                `OFF_DATA:  prdata_next = {24'h00_0000, rx_buf_reg};
                default:    pslverr_next = 1'b1;
            endcase
        end
    end

    always_comb
    begin
        wmask = 8'h00;
        wval  = 8'h00;
        if (wr && paddr == `OFF_SC)
        begin
            wmask = 8'hFF;
            wval  = pwdata[7:0];
        end
        else if (wr && paddr == `OFF_BITWR)
        begin
            wmask = 8'h01 << pwdata[2:0];
            wval  = {8{pwdata[`BW_VAL]}};
        end
    end

    always_comb
    begin
        serial_control_next = (serial_control_reg & ~wmask) | (wval & wmask);
        if (fe_sel)
            serial_control_next[`SC_MODE0] = serial_control_reg[`SC_MODE0];
        fe_next = fe_reg;
        if (fe_sel && wmask[`SC_MODE0])
            fe_next = wval[`SC_MODE0];
        fe_next = fe_next | fe_set;
        if (rb8_load)
            serial_control_next[`SC_RB8] = rb8_val;
        // hardware set wins over a software clear in the same cycle
        serial_control_next[`SC_TI] = serial_control_next[`SC_TI] | ti_set;
        serial_control_next[`SC_RI] = serial_control_next[`SC_RI] | ri_set;
        cfg_next   = (wr && paddr == `OFF_CFG) ? pwdata : cfg_reg;
        addr_next  = (wr && paddr == `OFF_ADDR) ? pwdata[15:0] : addr_reg;
        imask_next = (wr && paddr == `OFF_IMASK) ? pwdata[2:0]
                                                 : imask_reg;
        ist_next = ist_reg;
        if (wr && paddr == `OFF_IST)
            ist_next = ist_reg & ~pwdata[2:0];
        ist_next[`IRQ_TX] = ist_next[`IRQ_TX] | ti_set;
        ist_next[`IRQ_RX] = ist_next[`IRQ_RX] | ri_set;
        ist_next[`IRQ_FE] = ist_next[`IRQ_FE] | fe_set;
        irq_next    = |(ist_next & imask_next);
        rx_buf_next = rx_load ? rx_data : rx_buf_reg;
    end

    // mode 0 shift clock is low in the first half of each bit
    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_m0_next    = tx_m0_reg;
        txd_next      = txd_reg;
        rxd_out_next  = rxd_out_reg;
        oe_n_next     = oe_n_reg;
        ti_set        = 1'b0;
        case (tx_state_reg)
            TX_IDLE:
            begin
                if (tx_go)
                begin
                    tx_shift_next = {serial_control_reg[`SC_TB8], pwdata[7:0]};
                    tx_cnt_next   = 4'h0;
                    tx_m0_next    = mode == MODE_SHIFT;
                    txd_next      = 1'b0;
                    tx_state_next = TX_START;
                    if (mode == MODE_SHIFT)
                    begin
                        tx_state_next = TX_BITS;
                        rxd_out_next  = pwdata[0];
                        oe_n_next     = 1'b0;
                    end
                end
                else if (rx0_go)
                    txd_next = 1'b0;
                else if (rx_m0_busy && rx_bi.mid)
                    txd_next = 1'b1;
                else if (rx_m0_busy && rx_bi.tick && rx_cnt_reg != `LAST8)
                    txd_next = 1'b0;
            end
            TX_START:
                if (tx_bi.tick)
                begin
                    tx_state_next = TX_BITS;
                    txd_next      = tx_shift_reg[0];
                end
            TX_BITS:
                if (tx_m0_reg && tx_bi.mid)
                    txd_next = 1'b1;
                else if (tx_bi.tick)
                begin
                    if (tx_cnt_reg == ((nine && !tx_m0_reg) ? `LAST9
                                                            : `LAST8))
                    begin
                        ti_set        = 1'b1;
                        tx_state_next = tx_m0_reg ? TX_IDLE : TX_STOP;
                        txd_next      = 1'b1;
                        oe_n_next     = 1'b1;
                    end
                    else
                    begin
                        tx_cnt_next   = tx_cnt_reg + 4'h1;
                        tx_shift_next = {1'b0, tx_shift_reg[8:1]};
                        txd_next      = tx_m0_reg ? 1'b0 : tx_shift_reg[1];
                        rxd_out_next  = tx_shift_reg[1];
                    end
                end
            TX_STOP:
                if (tx_bi.tick)
                    tx_state_next = TX_IDLE;
            default:
            begin
                tx_state_next = TX_IDLE;
                txd_next      = 1'b1;
                oe_n_next     = 1'b1;
            end
        endcase
    end

    assign shifted = {rxd_sync_reg, rx_shift_reg[8:1]};
    assign rx_last = nine ? `LAST9 : `LAST8;
    assign bc_mask = addr_reg[7:0] | addr_reg[15:8];

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_m0_next    = rx_m0_reg;
        rx_start = 1'b0;
        ri_set   = 1'b0;
        fe_set   = 1'b0;
        rb8_load = 1'b0;
        rb8_val  = serial_control_reg[`SC_RB8];
        rx_load  = 1'b0;
        rx_data  = rx_shift_reg[8:1];
        ev_go    = 1'b0;
        ev_data  = rx_shift_reg[8:1];
        ev_ninth = rxd_sync_reg;
        if (!ren)
            rx_state_next = RX_IDLE;
        else
            case (rx_state_reg)
                RX_IDLE:
                    if (rx0_go || (mode != MODE_SHIFT && rxd_prev_reg
                                   && !rxd_sync_reg))
                    begin
                        rx_start      = 1'b1;
                        rx_m0_next    = rx0_go;
                        rx_cnt_next   = 4'h0;
                        rx_state_next = rx0_go ? RX_BITS : RX_START;
                    end
                RX_START:
                    if (rx_bi.mid && rxd_sync_reg)
                        rx_state_next = RX_IDLE;
                    else if (rx_bi.tick)
                        rx_state_next = RX_BITS;
                RX_BITS:
                    if (rx_bi.mid)
                    begin
                        rx_shift_next = shifted;
                        if (!rx_m0_reg && rx_cnt_reg == rx_last)
                        begin
                            rx_state_next = RX_STOP;
                            // without framing check 9-bit frames end here
                            ev_go    = nine && !fe_sel;
                            ev_data  = shifted[7:0];
                            ev_ninth = shifted[8];
                        end
                        else if (!rx_m0_reg)
                            rx_cnt_next = rx_cnt_reg + 4'h1;
                    end
                    else if (rx_m0_reg && rx_bi.tick)
                    begin
                        rx_cnt_next = rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == `LAST8)
                        begin
                            ri_set        = 1'b1;
                            rx_load       = 1'b1;
                            rx_state_next = RX_IDLE;
                        end
                    end
                RX_STOP:
                    if (rx_bi.mid)
                    begin
                        rx_state_next = RX_IDLE;
                        fe_set = fe_sel && !rxd_sync_reg;
                        ev_go  = !(nine && !fe_sel);
                        ev_data  = nine ? rx_shift_reg[7:0]
                                        : rx_shift_reg[8:1];
                        ev_ninth = nine ? rx_shift_reg[8] : rxd_sync_reg;
                    end
                default:
                    rx_state_next = RX_IDLE;
            endcase
        // the ninth bit (stop bit in mode 1) marks an address frame
        if (ev_go && !serial_control_reg[`SC_RI] && (!mp || (ev_ninth
            && (((ev_data ^ addr_reg[7:0]) & addr_reg[15:8]) == 8'h00
                || (ev_data & bc_mask) == bc_mask))))
        begin
            ri_set   = 1'b1;
            rx_load  = 1'b1;
            rx_data  = ev_data;
            rb8_load = 1'b1;
            rb8_val  = ev_ninth;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            rxd_prev_reg <= 1'b1;
        end
        else
        begin
            rxd_meta_reg <= rxd_in;
            rxd_sync_reg <= rxd_meta_reg;
            rxd_prev_reg <= rxd_sync_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_control_reg     <= `SC_RESET;
            fe_reg       <= 1'b0;
            cfg_reg      <= `CFG_RESET;
            addr_reg     <= `ADDR_RESET;
            ist_reg      <= `IRQ_RESET;
            imask_reg    <= `IRQ_RESET;
            irq_reg      <= 1'b0;
            rx_buf_reg   <= 8'h00;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            prdata_reg   <= 32'h0000_0000;
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 9'h000;
            tx_cnt_reg   <= 4'h0;
            tx_m0_reg    <= 1'b0;
            txd_reg      <= 1'b1;
            rxd_out_reg  <= 1'b1;
            oe_n_reg     <= 1'b1;
            rx_state_reg <= RX_IDLE;
            rx_shift_reg <= 9'h000;
            rx_cnt_reg   <= 4'h0;
            rx_m0_reg    <= 1'b0;
        end
        else
        begin
            serial_control_reg     <= serial_control_next;
            fe_reg       <= fe_next;
            cfg_reg      <= cfg_next;
            addr_reg     <= addr_next;
            ist_reg      <= ist_next;
            imask_reg    <= imask_next;
            irq_reg      <= irq_next;
            rx_buf_reg   <= rx_buf_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            prdata_reg   <= prdata_next;
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_m0_reg    <= tx_m0_next;
            txd_reg      <= txd_next;
            rxd_out_reg  <= rxd_out_next;
            oe_n_reg     <= oe_n_next;
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_m0_reg    <= rx_m0_next;
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign txd_out  = txd_reg;
    assign rxd_out  = rxd_out_reg;
    assign rxd_oe_n = oe_n_reg;
    assign irq      = irq_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_fe_sticky: assert property (
        fe_reg && !(fe_sel && wmask[7] && !wval[7]) |=> fe_reg)
        else $error("framing error flag dropped without a clear");
    chk_bit7_route: assert property (
        fe_sel && wmask[7] |=> $stable(serial_control_reg[`SC_MODE0]))
        else $error("mode bit 0 written while error flag selected");
    chk_mode0_ti: assert property (
        tx_go && mode == MODE_SHIFT && !cfg_reg[`CFG_X2] |-> ##96 ti_set)
        else $error("mode 0 tx done not after eight bit times");
    chk_ti_stop: assert property (
        ti_set && !tx_m0_reg |=> tx_state_reg == TX_STOP && txd_reg)
        else $error("tx done not at start of stop bit");
    chk_ti_hold: assert property (
        serial_control_reg[`SC_TI] && !(wmask[`SC_TI] && !wval[`SC_TI])
        |=> serial_control_reg[`SC_TI])
        else $error("tx done cleared by hardware");
    chk_ri_hold: assert property (
        serial_control_reg[`SC_RI] && !(wmask[`SC_RI] && !wval[`SC_RI])
        |=> serial_control_reg[`SC_RI])
        else $error("rx done cleared by hardware");
    chk_rx_enable: assert property (
        ri_set |-> ren)
        else $error("frame accepted while reception disabled");
    chk_mp_address: assert property (
        ri_set && mp |-> rb8_val)
        else $error("data frame accepted in multiprocessor mode");
    chk_rb8_load: assert property (
        rb8_load && nine |=> serial_control_reg[`SC_RB8] == $past(rx_shift_next[8]))
        else $error("ninth bit not stored");
    chk_ri_stop: assert property (
        ri_set && fe_sel && !rx_m0_reg |-> rx_state_reg == RX_STOP)
        else $error("rx done not at stop bit with framing check");
    chk_ninth_tx: assert property (
        tx_go && nine |=> tx_shift_reg[8] == $past(serial_control_reg[`SC_TB8]))
        else $error("ninth tx bit not taken from control register");

    cov_frame_err: cover property (fe_set && ri_set);
    cov_mode0_rx:  cover property (ri_set && rx_m0_reg);
    cov_mp_accept: cover property (ri_set && mp);
    cov_async_tx:  cover property (ti_set && !tx_m0_reg && nine);
endmodule // uart_serial_control

//--- dv/serial_node.sv
// remote serial node that drives frames onto the receive pin
`timescale 1ns/10ps
module serial_node (
    input  wire logic pclk, // bench clock
    output logic      line  // data line toward the port, idles high
);
    initial line = 1'b1;
    // start bit, eight data bits lsb first, then a chosen stop level
    task automatic send(input logic [7:0] d, input logic stop, input int per);
        logic [9:0] frame;
        frame = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge pclk);
            line <= frame[i];
            repeat (per - 1) @(posedge pclk);
        end
        @(posedge pclk);
        line <= 1'b1;
    endtask
endmodule // serial_node

//--- dv/test_uart_serial_control.sv
// self-checking bench for the serial control block
`timescale 1ns/10ps
module test_uart_serial_control;
    logic pclk, presetn, psel, penable, pwrite, rxd_in, pready, pslverr;
    logic txd_out, irq, rxd_out, rxd_oe_n;
    uart_pkg::apb_addr_t paddr;
    uart_pkg::apb_data_t pwdata, prdata;
    logic [32:0] q[$];
    int fail_count = 0, checked = 0, seed = 99022, n;
    logic [7:0] b1, b2, b3;
    uart_serial_control uart_serial_control_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe_n(rxd_oe_n),
        .txd_out(txd_out), .irq(irq));
    serial_node serial_node_inst (.pclk(pclk), .line(rxd_in));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // waits for the start bit, then samples each bit near its middle
    task automatic see_tx(input logic [10:0] f, input int nb);
        n = 0;
        while (txd_out !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
        if (n >= 100) fail_count++;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < nb; i++)
        begin
            check({32'h0, txd_out}, {32'h0, f[i]});
            repeat (16) @(posedge pclk);
        end
    endtask
    // one apb transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic w, input uart_pkg::apb_addr_t a,
                       input uart_pkg::apb_data_t d, input logic [32:0] e);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        if (!w) q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin fail_count++; give_verdict(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, q.pop_front());
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        repeat (50000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0;
        b1 = $random(seed); b2 = $random(seed); b3 = $random(seed);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h98, 0, 33'h0);
        apb(1, 8'h9C, 32'h0000_1001, 0);
        apb(1, 8'h98, 32'h50, 0);
        apb(1, 8'hB0, {24'h0, b1}, 0);
        see_tx({2'b11, b1, 1'b0}, 10);
        apb(0, 8'h98, 0, 33'h52);
        apb(1, 8'h98, 32'h50, 0);
        apb(0, 8'h98, 0, 33'h50);
        serial_node_inst.send(b2, 1'b0, 16);
        repeat (20) @(posedge pclk);
        apb(0, 8'h98, 0, 33'hD1);
        apb(1, 8'h98, 32'hD0, 0);
        serial_node_inst.send(b3, 1'b1, 16);
        repeat (20) @(posedge pclk);
        apb(0, 8'h98, 0, 33'hD5);
        apb(0, 8'hB0, 0, {25'h0, b3});
        apb(1, 8'hA8, 32'h2, 0);
        repeat (3) @(posedge pclk);
        check({32'h0, irq}, 33'h1);
        apb(1, 8'hA4, 32'h7, 0);
        repeat (3) @(posedge pclk);
        check({32'h0, irq}, 33'h0);
        apb(1, 8'h98, 32'h40, 0);
        serial_node_inst.send(b1, 1'b1, 16);
        repeat (20) @(posedge pclk);
        apb(0, 8'h98, 0, 33'h40);
        apb(1, 8'hAC, 32'hC, 0);
        apb(0, 8'h98, 0, 33'h50);
        // mode 3, doubler halves a period of 32 to 16
        apb(1, 8'h9C, 32'h0000_2002, 0);
        apb(1, 8'h98, 32'hC8, 0);
        apb(1, 8'hB0, {24'h0, b2}, 0);
        see_tx({2'b11, b2, 1'b0}, 11);
        apb(1, 8'hA0, 32'hFFA5, 0);
        apb(1, 8'h98, 32'hF0, 0);
        serial_node_inst.send(8'h5A, 1'b1, 16);
        repeat (20) @(posedge pclk);
        serial_node_inst.send(b2, 1'b0, 16);
        repeat (20) @(posedge pclk);
        apb(0, 8'h98, 0, 33'hF0);
        serial_node_inst.send(8'hA5, 1'b1, 16);
        repeat (20) @(posedge pclk);
        apb(0, 8'h98, 0, 33'hF5);
        apb(0, 8'hB0, 0, 33'hA5);
        // mode 0 receive shifts in the idle-high line
        apb(1, 8'h98, 32'h10, 0);
        repeat (120) @(posedge pclk);
        apb(0, 8'h98, 0, 33'h11);
        apb(0, 8'hB0, 0, 33'hFF);
        apb(1, 8'h98, 32'h00, 0);
        apb(1, 8'hB0, {24'h0, b3}, 0);
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            check({31'h0, rxd_oe_n, rxd_out}, {32'h0, b3[i]});
            repeat (12) @(posedge pclk);
        end
        check({32'h0, rxd_oe_n}, 33'h1);
        apb(0, 8'h98, 0, 33'h02);
        apb(0, 8'hC0, 0, {1'b1, 32'h0});
        repeat (3) @(posedge pclk);
        check(33'(q.size()), 33'h0);
        give_verdict();
    end
endmodule // test_uart_serial_control
